/* design/arpp_cfg.svh */
`ifndef ARPP_CFG_SVH
`define ARPP_CFG_SVH

// ****************
// Register map
// ****************
`define ARPP_STATUS_ADDR 32'hFFFF0500
`define ARPP_CONFIG_ADDR 32'hFFFF0504
`define ARPP_MODE_ADDR   32'hFFFF0508
`define ARPP_CTRL_ADDR   32'hFFFF050C
`define ARPP_MASK_ADDR   32'hFFFF0510
`define ARPP_CUR_ADDR    32'hFFFF0520
`define ARPP_VOLT_ADDR   32'hFFFF0524
`define ARPP_TEMP_ADDR   32'hFFFF0528
`define ARPP_QUEUE_ADDR  32'hFFFF052C
`define ARPP_OFF0_ADDR   32'hFFFF0530
`define ARPP_OFF1_ADDR   32'hFFFF0534
`define ARPP_OFF2_ADDR   32'hFFFF0538
`define ARPP_GAIN0_ADDR  32'hFFFF053C
`define ARPP_GAIN1_ADDR  32'hFFFF0540
`define ARPP_GAIN2_ADDR  32'hFFFF0544
`define ARPP_RCL_ADDR    32'hFFFF0548
`define ARPP_RCV_ADDR    32'hFFFF054C
`define ARPP_TH_ADDR     32'hFFFF0550
`define ARPP_THL_ADDR    32'hFFFF0554
`define ARPP_THV_ADDR    32'hFFFF0558
`define ARPP_ACC_ADDR    32'hFFFF055C
`define ARPP_ATH_ADDR    32'hFFFF0560

// ****************
// Reset values
// ****************
`define ARPP_RCL_RESET  16'h0001
`define ARPP_THL_RESET  8'h01
`define ARPP_MASK_RESET 9'h1C0

// ****************
// Fields
// ****************
`define ARPP_CFG_RCEN 0
`define ARPP_CFG_QEN  1
`define ARPP_CFG_TWOS 7
`define ARPP_MODE_VEN 8
`define ARPP_MODE_TEN 9
`define ARPP_CTRL_IEN 15
`define ARPP_MODE_IDLE   3'h3
`define ARPP_MODE_OFFCAL 3'h4
`define ARPP_MODE_GAINCAL 3'h5
`define ARPP_CMP_OFF 2'h0
`define ARPP_CMP_ANY 2'h1
`define ARPP_CMP_CLR 2'h2
`define ARPP_ACC_OFF 2'h0
`define ARPP_ACC_SUB 2'h2
`define ARPP_ST_QNE  3
`define ARPP_ST_QFUL 4
`define ARPP_ST_QOVF 5
`define ARPP_ST_THR  6
`define ARPP_ST_ACC  7
`define ARPP_ST_CNT  8

// ****************
// Queue geometry
// ****************
`define ARPP_QAW   5
`define ARPP_QFULL 6'h20

// ****************
// Software timing
// ****************
// Coefficient write to mode change, 23us at 40 MHz
`define ARPP_COEF_WAIT 920

`endif

/* design/arpp_pkg.sv */
package arpp_pkg;
`include "arpp_cfg.svh"

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} arpp_result_t;

	typedef struct packed {
		logic        valid;
		logic [1:0]  chan;
		logic [15:0] data;
	} arpp_cal_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} arpp_bus_t;

	typedef struct packed {
		logic [2:0][15:0]    res;
		logic [8:0]          status;
		logic [2:0][15:0]    offs;
		logic [2:0][15:0]    gain;
		logic [15:0]         cfg;
		logic [15:0]         mode;
		logic [15:0]         ctrl;
		logic [8:0]          mask;
		logic [15:0]         rcLimit;
		logic [15:0]         rcCount;
		logic [15:0]         thresh;
		logic [7:0]          thLimit;
		logic [7:0]          thCount;
		logic [31:0]         acc;
		logic [31:0]         accTh;
		logic [`ARPP_QAW:0]  wrPtr;
		logic [`ARPP_QAW:0]  rdPtr;
		logic [31:0]         rdData;
		logic                irq;
	} arpp_state_t;

endpackage

/* design/arpp_top.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Current result held while its ready set
// RULE2 - Current result read clears ready bits 2:0
// RULE3 - Voltage result held while its ready set
// RULE4 - Voltage read, current idle, clears bits 2:1
// RULE5 - Temperature result held while its ready set
// RULE6 - Queue read returns current low, voltage high
// RULE7 - Queue runs only when enabled, three flags
// RULE8 - Offset coefficients: factory reset, calibration overwrite
// RULE9 - Gain coefficients: factory reset, calibration overwrite
// RULE10 - Coefficient writes only when enabled and idle
// RULE11 - Software waits 23us before mode change
// RULE12 - Count limit resets to one, enable-gated
// RULE13 - Count advances, wraps to zero at limit
// RULE14 - Control or mode write zeroes count
// RULE15 - Magnitude compare, width depends on coding
// RULE16 - Hit count reaching limit flags threshold
// RULE17 - Hit count rises, falls or clears
// RULE18 - Comparator mode selects disabled, any, counted
// RULE19 - Accumulator zeroed when disabled or on control write
// RULE20 - Accumulator adds or subtracts each result
// RULE21 - Software reads accumulator after ready flag
// RULE22 - Accumulator threshold register resets zero
// RULE23 - Accumulator crossing threshold sets flag, interrupt
// RULE24 - Counter off: event on every conversion
`include "arpp_cfg.svh"

module arpp_top #(
	parameter logic [15:0] OFF_FACTORY  = 16'h0000,
	parameter logic [15:0] GAIN_FACTORY = 16'h8000
) (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	// Register port
	input  wire arpp_pkg::arpp_bus_t   busReq,
	output logic [31:0]                rdData,
	// Filter results
	input  wire arpp_pkg::arpp_result_t curIn,
	input  wire arpp_pkg::arpp_result_t voltIn,
	input  wire arpp_pkg::arpp_result_t tempIn,
	input  wire arpp_pkg::arpp_cal_t   calIn,
	// Coefficients to filters, interrupt
	output logic [2:0][15:0]           offsCoef,
	output logic [2:0][15:0]           gainCoef,
	output logic                       irq
);

	localparam int DEPTH = 1 << `ARPP_QAW;

	arpp_pkg::arpp_state_t q;
	arpp_pkg::arpp_state_t d;
	logic [31:0]           qMem [DEPTH];
	logic [`ARPP_QAW:0]    fill;
	logic                  qPush;
	logic                  reconf;
	logic                  ctrlWr;
	logic [7:0]            thNext;
	logic [15:0]           cnt1;

	// ****************
	// Helpers
	// ****************
	function automatic logic magGe(input logic [15:0] v, input logic [15:0] th,
			input logic twos);
		logic [15:0] m;
		m = (twos && v[15]) ? 16'(~v + 16'h0001) : v;
		if (twos)
			magGe = m[14:0] >= th[14:0];
		else
			magGe = v >= th;
	endfunction

	function automatic logic coefOk(input logic en, input logic [15:0] mode);
		coefOk = en && (mode[2:0] == `ARPP_MODE_IDLE);
	endfunction

	assign fill   = q.wrPtr - q.rdPtr;
	assign qPush  = curIn.valid && q.cfg[`ARPP_CFG_QEN] && (fill != `ARPP_QFULL);
	assign ctrlWr = busReq.wr && (busReq.addr == `ARPP_CTRL_ADDR);
	assign reconf = ctrlWr || (busReq.wr && (busReq.addr == `ARPP_MODE_ADDR));
	assign cnt1   = q.rcCount + 16'h0001;
	assign thNext = magGe(curIn.data, q.thresh, q.cfg[`ARPP_CFG_TWOS]) ?
		((q.thCount == 8'hFF) ? q.thCount : q.thCount + 8'h01) :
		((q.cfg[4:3] == `ARPP_CMP_CLR || q.thCount == 8'h00) ? 8'h00 :
		q.thCount - 8'h01);

	// ****************
	// Next state
	// ****************
	always_comb begin
		logic [2:0]  clr;
		logic [31:0] sx;
		logic [31:0] accN;
		logic        hit;
		clr  = 3'h0;
		sx   = 32'h0;
		accN = q.acc;
		hit  = 1'b0;
		d    = q;
		d.rdData = 32'h0;
		if (busReq.rd) begin
			case (busReq.addr)
				`ARPP_STATUS_ADDR: begin
					d.rdData = {23'h0, q.status};
					d.status[8:5] = 4'h0;
				end
				`ARPP_CONFIG_ADDR: d.rdData = {16'h0, q.cfg};
				`ARPP_MODE_ADDR:   d.rdData = {16'h0, q.mode};
				`ARPP_CTRL_ADDR:   d.rdData = {16'h0, q.ctrl};
				`ARPP_MASK_ADDR:   d.rdData = {23'h0, q.mask};
				`ARPP_CUR_ADDR: begin
					d.rdData = {16'h0, q.res[0]};
					clr = 3'h7; // RULE2
				end
				`ARPP_VOLT_ADDR: begin
					d.rdData = {16'h0, q.res[1]};
					if (!q.ctrl[`ARPP_CTRL_IEN])
						clr = 3'h6; // RULE4
				end
				`ARPP_TEMP_ADDR:   d.rdData = {16'h0, q.res[2]};
				`ARPP_QUEUE_ADDR: begin
					d.rdData = qMem[q.rdPtr[`ARPP_QAW-1:0]]; // RULE6
					if (fill != '0)
						d.rdPtr = q.rdPtr + 1'b1;
				end
				`ARPP_OFF0_ADDR:   d.rdData = {16'h0, q.offs[0]};
				`ARPP_OFF1_ADDR:   d.rdData = {16'h0, q.offs[1]};
				`ARPP_OFF2_ADDR:   d.rdData = {16'h0, q.offs[2]};
				`ARPP_GAIN0_ADDR:  d.rdData = {16'h0, q.gain[0]};
				`ARPP_GAIN1_ADDR:  d.rdData = {16'h0, q.gain[1]};
				`ARPP_GAIN2_ADDR:  d.rdData = {16'h0, q.gain[2]};
				`ARPP_RCL_ADDR:    d.rdData = {16'h0, q.rcLimit};
				`ARPP_RCV_ADDR:    d.rdData = {16'h0, q.rcCount};
				`ARPP_TH_ADDR:     d.rdData = {16'h0, q.thresh};
				`ARPP_THL_ADDR:    d.rdData = {24'h0, q.thLimit};
				`ARPP_THV_ADDR:    d.rdData = {24'h0, q.thCount};
				`ARPP_ACC_ADDR:    d.rdData = q.acc;
				`ARPP_ATH_ADDR:    d.rdData = q.accTh;
				default:           d.rdData = 32'h0;
			endcase
		end
		d.status[2:0] = q.status[2:0] & ~clr;
		if (busReq.wr) begin
			case (busReq.addr)
				`ARPP_CONFIG_ADDR: d.cfg  = busReq.wdata[15:0];
				`ARPP_MODE_ADDR:   d.mode = busReq.wdata[15:0];
				`ARPP_CTRL_ADDR:   d.ctrl = busReq.wdata[15:0];
				`ARPP_MASK_ADDR:   d.mask = busReq.wdata[8:0];
				`ARPP_OFF0_ADDR:
					if (coefOk(q.ctrl[`ARPP_CTRL_IEN], q.mode))
						d.offs[0] = busReq.wdata[15:0]; // RULE10
				`ARPP_OFF1_ADDR:
					if (coefOk(q.mode[`ARPP_MODE_VEN], q.mode))
						d.offs[1] = busReq.wdata[15:0]; // RULE10
				`ARPP_OFF2_ADDR:
					if (coefOk(q.mode[`ARPP_MODE_TEN], q.mode))
						d.offs[2] = busReq.wdata[15:0]; // RULE10
				`ARPP_GAIN0_ADDR:
					if (coefOk(q.ctrl[`ARPP_CTRL_IEN], q.mode))
						d.gain[0] = busReq.wdata[15:0]; // RULE10
				`ARPP_GAIN1_ADDR:
					if (coefOk(q.mode[`ARPP_MODE_VEN], q.mode))
						d.gain[1] = busReq.wdata[15:0]; // RULE10
				`ARPP_GAIN2_ADDR:
					if (coefOk(q.mode[`ARPP_MODE_TEN], q.mode))
						d.gain[2] = busReq.wdata[15:0]; // RULE10
				`ARPP_RCL_ADDR:    d.rcLimit = busReq.wdata[15:0];
				`ARPP_TH_ADDR:     d.thresh  = busReq.wdata[15:0];
				`ARPP_THL_ADDR:    d.thLimit = busReq.wdata[7:0];
				`ARPP_ATH_ADDR:    d.accTh   = busReq.wdata; // RULE22
				default: ;
			endcase
		end
		// Calibration result lands in the coefficient picked by mode
		if (calIn.valid && calIn.chan != 2'h3) begin
			if (q.mode[2:0] == `ARPP_MODE_OFFCAL)
				d.offs[calIn.chan] = calIn.data; // RULE8
			else if (q.mode[2:0] == `ARPP_MODE_GAINCAL)
				d.gain[calIn.chan] = calIn.data; // RULE9
		end
		if (voltIn.valid && !q.status[1]) begin
			d.res[1] = voltIn.data; // RULE3
			d.status[1] = 1'b1;
		end
		if (tempIn.valid && !q.status[2]) begin
			d.res[2] = tempIn.data; // RULE5
			d.status[2] = 1'b1;
		end
		if (curIn.valid) begin
			if (!q.status[0]) begin
				d.res[0] = curIn.data; // RULE1
				d.status[0] = 1'b1;
			end
			if (qPush)
				d.wrPtr = q.wrPtr + 1'b1;
			else if (q.cfg[`ARPP_CFG_QEN])
				d.status[`ARPP_ST_QOVF] = 1'b1;
			if (!q.cfg[`ARPP_CFG_RCEN])
				d.status[`ARPP_ST_CNT] = 1'b1; // RULE24
			else if (cnt1 == q.rcLimit) begin
				d.rcCount = 16'h0; // RULE13
				d.status[`ARPP_ST_CNT] = 1'b1; // RULE12
			end else
				d.rcCount = cnt1; // RULE13
			hit = magGe(curIn.data, q.thresh, q.cfg[`ARPP_CFG_TWOS]); // RULE15
			case (q.cfg[4:3]) // RULE18
				`ARPP_CMP_OFF: ;
				`ARPP_CMP_ANY:
					if (hit)
						d.status[`ARPP_ST_THR] = 1'b1;
				default: begin
					d.thCount = thNext; // RULE17
					if (hit && thNext == q.thLimit)
						d.status[`ARPP_ST_THR] = 1'b1; // RULE16
				end
			endcase
			sx = q.cfg[`ARPP_CFG_TWOS] ? {{16{curIn.data[15]}}, curIn.data} :
				{16'h0, curIn.data};
			accN = (q.cfg[6:5] == `ARPP_ACC_SUB) ? q.acc - sx : q.acc + sx; // RULE20
			d.acc = accN;
			if ($signed(q.acc) < $signed(q.accTh) && $signed(accN) >= $signed(q.accTh)
					&& q.cfg[6:5] != `ARPP_ACC_OFF)
				d.status[`ARPP_ST_ACC] = 1'b1; // RULE23
		end
		if (reconf)
			d.rcCount = 16'h0; // RULE14
		if (q.cfg[6:5] == `ARPP_ACC_OFF || ctrlWr)
			d.acc = 32'h0; // RULE19
		if (!q.cfg[`ARPP_CFG_QEN]) begin
			d.wrPtr = '0; // RULE7
			d.rdPtr = '0;
		end
		d.status[`ARPP_ST_QNE]  = d.wrPtr != d.rdPtr; // RULE7
		d.status[`ARPP_ST_QFUL] = (d.wrPtr - d.rdPtr) == `ARPP_QFULL;
		d.irq = |(d.status & d.mask); // RULE23
	end

	// ****************
	// Registers
	// ****************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			q         <= '0;
			q.offs    <= {3{OFF_FACTORY}}; // RULE8
			q.gain    <= {3{GAIN_FACTORY}}; // RULE9
			q.rcLimit <= `ARPP_RCL_RESET; // RULE12
			q.thLimit <= `ARPP_THL_RESET; // RULE16
			q.mask    <= `ARPP_MASK_RESET;
		end else begin
			q <= d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (qPush)
			qMem[q.wrPtr[`ARPP_QAW-1:0]] <= {q.res[1], curIn.data}; // RULE6
	end

	assign rdData   = q.rdData;
	assign irq      = q.irq;
	assign offsCoef = q.offs;
	assign gainCoef = q.gain;

	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence sCurRead;
		busReq.rd && busReq.addr == `ARPP_CUR_ADDR;
	endsequence
	sequence sNoNew;
		!curIn.valid && !voltIn.valid && !tempIn.valid;
	endsequence
	sequence sAccBelow;
		curIn.valid && q.cfg[6:5] != `ARPP_ACC_OFF && $signed(q.acc) < $signed(q.accTh);
	endsequence
	sequence sQueueFull;
		curIn.valid && q.cfg[`ARPP_CFG_QEN] && fill == `ARPP_QFULL;
	endsequence

	rd_only_after_a: assert property (!$past(busReq.rd) |-> rdData == 32'h0)
		else $error("read data outside answer cycle");
	cur_hold_a: assert property (q.status[0] |=> q.res[0] == $past(q.res[0])) // RULE1
		else $error("current result changed while ready");
	cur_clear_a: assert property (sCurRead ##0 sNoNew |=> q.status[2:0] == 3'h0) // RULE2
		else $error("current read left ready flags");
	volt_hold_a: assert property (q.status[1] |=> q.res[1] == $past(q.res[1])) // RULE3
		else $error("voltage result changed while ready");
	volt_clear_a: assert property (busReq.rd && busReq.addr == `ARPP_VOLT_ADDR // RULE4
			&& !q.ctrl[`ARPP_CTRL_IEN] && !busReq.wr ##0 sNoNew |=> q.status[2:1] == 2'h0)
		else $error("voltage read left ready flags");
	temp_hold_a: assert property (q.status[2] |=> q.res[2] == $past(q.res[2])) // RULE5
		else $error("temperature result changed while ready");
	queue_off_a: assert property (!q.cfg[`ARPP_CFG_QEN] |=> q.wrPtr == q.rdPtr // RULE7
			&& !q.status[`ARPP_ST_QNE])
		else $error("queue active while disabled");
	coef_guard_a: assert property (busReq.wr && busReq.addr == `ARPP_OFF0_ADDR // RULE10
			&& !coefOk(q.ctrl[`ARPP_CTRL_IEN], q.mode) && !calIn.valid
			|=> q.offs[0] == $past(q.offs[0]))
		else $error("offset write outside idle took effect");
	count_wrap_a: assert property (curIn.valid && q.cfg[`ARPP_CFG_RCEN] // RULE13
			&& cnt1 == q.rcLimit |=> q.rcCount == 16'h0 && q.status[`ARPP_ST_CNT])
		else $error("result count did not wrap at limit");
	count_zero_a: assert property (reconf |=> q.rcCount == 16'h0) // RULE14
		else $error("result count survived reconfiguration");
	thr_hit_a: assert property (curIn.valid && q.cfg[4:3] != `ARPP_CMP_OFF // RULE16
			&& q.cfg[4:3] != `ARPP_CMP_ANY && thNext == q.thLimit
			&& magGe(curIn.data, q.thresh, q.cfg[`ARPP_CFG_TWOS])
			|=> q.status[`ARPP_ST_THR] && q.thCount == $past(thNext))
		else $error("threshold flag missed at hit limit");
	acc_off_a: assert property (q.cfg[6:5] == `ARPP_ACC_OFF |=> q.acc == 32'h0) // RULE19
		else $error("accumulator not cleared while disabled");
	queue_push_a: assert property (qPush |=> // RULE6
			qMem[$past(q.wrPtr[`ARPP_QAW-1:0])] == {$past(q.res[1]), $past(curIn.data)})
		else $error("queue entry not written as pair");
	queue_read_a: assert property (busReq.rd && busReq.addr == `ARPP_QUEUE_ADDR // RULE6
			|=> rdData == $past(qMem[q.rdPtr[`ARPP_QAW-1:0]]))
		else $error("queue read returned wrong entry");
	queue_ovf_a: assert property (sQueueFull |=> q.status[`ARPP_ST_QOVF] // RULE7
			&& q.wrPtr == $past(q.wrPtr))
		else $error("full queue took a new pair");
	count_off_a: assert property (curIn.valid && !q.cfg[`ARPP_CFG_RCEN] // RULE24
			|=> q.status[`ARPP_ST_CNT])
		else $error("conversion event missing with counter off");
	thr_any_a: assert property (curIn.valid && q.cfg[4:3] == `ARPP_CMP_ANY // RULE18
			&& magGe(curIn.data, q.thresh, q.cfg[`ARPP_CFG_TWOS]) |=> q.status[`ARPP_ST_THR])
		else $error("comparator hit not flagged");
	acc_add_a: assert property (curIn.valid && q.cfg[6:5] == 2'h1 // RULE20
			&& !q.cfg[`ARPP_CFG_TWOS] && !ctrlWr
			|=> q.acc == $past(q.acc) + {16'h0, $past(curIn.data)})
		else $error("accumulator did not add result");
	acc_sub_a: assert property (curIn.valid && q.cfg[6:5] == `ARPP_ACC_SUB // RULE20
			&& !q.cfg[`ARPP_CFG_TWOS] && !ctrlWr
			|=> q.acc == $past(q.acc) - {16'h0, $past(curIn.data)})
		else $error("accumulator did not subtract result");
	acc_cross_a: assert property (sAccBelow ##0 !ctrlWr |=> // RULE23
			$signed(q.acc) >= $signed($past(q.accTh)) |-> q.status[`ARPP_ST_ACC])
		else $error("accumulator crossing not flagged");
	cal_off_a: assert property (calIn.valid && calIn.chan != 2'h3 // RULE8
			&& q.mode[2:0] == `ARPP_MODE_OFFCAL
			|=> q.offs[$past(calIn.chan)] == $past(calIn.data))
		else $error("offset calibration result not stored");

endmodule

/* verification/arpp_flt_model.sv */
`timescale 1ns/1ps
module arpp_flt_model (
	// Clock
	input  wire logic              ref_clk,
	// Filter results and calibration
	output arpp_pkg::arpp_result_t curOut,
	output arpp_pkg::arpp_result_t voltOut,
	output arpp_pkg::arpp_result_t tempOut,
	output arpp_pkg::arpp_cal_t    calOut
);
	logic [3:0]  vld = 4'h0;
	logic [15:0] dat = 16'h0000;
	logic [1:0]  calCh = 2'h0;

	assign curOut  = '{vld[0], dat};
	assign voltOut = '{vld[1], dat};
	assign tempOut = '{vld[2], dat};
	assign calOut  = '{vld[3], calCh, dat};

	// ****************
	// One result pulse; k 0..2 channel, 3 calibration
	// ****************
	task automatic send(input int k, input logic [1:0] c, input logic [15:0] d);
		@(posedge ref_clk);
		vld <= 4'h1 << k;
		calCh <= c;
		dat <= d;
		@(posedge ref_clk);
		vld <= 4'h0;
		dat <= ~d;
		#1;
	endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
`include "arpp_cfg.svh"
module tb;
	logic                   ref_clk = 1'b0;
	logic                   rst_b = 1'b0;
	arpp_pkg::arpp_bus_t    busReq = '0;
	logic [31:0]            rdData;
	arpp_pkg::arpp_result_t curIn;
	arpp_pkg::arpp_result_t voltIn;
	arpp_pkg::arpp_result_t tempIn;
	arpp_pkg::arpp_cal_t    calIn;
	logic [2:0][15:0]       offsCoef;
	logic [2:0][15:0]       gainCoef;
	logic                   irq;
	int                     fails = 0;
	int                     checked = 0;

	always #12.5 ref_clk = ~ref_clk;

	arpp_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .busReq(busReq), .rdData(rdData),
		.curIn(curIn), .voltIn(voltIn), .tempIn(tempIn), .calIn(calIn),
		.offsCoef(offsCoef), .gainCoef(gainCoef), .irq(irq));

	arpp_flt_model i_flt (.ref_clk(ref_clk), .curOut(curIn), .voltOut(voltIn),
		.tempOut(tempIn), .calOut(calIn));

	// ****************
	// Bus access and compare
	// ****************
	task automatic cmp(input logic [31:0] a, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] item %h expected %h seen %h", a, e, s);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		busReq <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		busReq <= '0;
	endtask

	task automatic chk(input logic [31:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge ref_clk);
		busReq <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge ref_clk);
		busReq <= '0;
		#1;
		cmp(a, rdData & m, e);
	endtask

	task automatic stop_test;
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#200us;
		fails++;
		stop_test();
	end

	// ****************
	// Tests
	// ****************
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk(`ARPP_RCL_ADDR, 32'h1);
		chk(`ARPP_THL_ADDR, 32'h1);
		chk(`ARPP_ATH_ADDR, 32'h0);
		chk(`ARPP_CUR_ADDR, 32'h0);
		chk(32'hFFFF05F0, 32'h0);
		cmp(1, {offsCoef[0], gainCoef[0]}, 32'h00008000);
		// Ready interlock
		wr(`ARPP_CTRL_ADDR, 32'h8000);
		wr(`ARPP_MODE_ADDR, 32'h0303);
		i_flt.send(0, 0, 16'h1234);
		i_flt.send(1, 0, 16'h5678);
		i_flt.send(2, 0, 16'h0ABC);
		cmp(2, irq, 1);
		i_flt.send(0, 0, 16'h1111);
		i_flt.send(1, 0, 16'h9999);
		i_flt.send(2, 0, 16'h0DEF);
		chk(`ARPP_VOLT_ADDR, 32'h5678);
		chk(`ARPP_TEMP_ADDR, 32'h0ABC);
		chk(`ARPP_STATUS_ADDR, 32'h7, 32'h7);
		chk(`ARPP_CUR_ADDR, 32'h1234);
		chk(`ARPP_STATUS_ADDR, 32'h0, 32'h7);
		repeat (2) @(posedge ref_clk);
		#1 cmp(3, irq, 0);
		// Voltage read with current channel off
		wr(`ARPP_CTRL_ADDR, 32'h0);
		i_flt.send(1, 0, 16'h2222);
		i_flt.send(2, 0, 16'h3333);
		chk(`ARPP_VOLT_ADDR, 32'h2222);
		chk(`ARPP_STATUS_ADDR, 32'h0, 32'h6);
		// Coefficient write gating and calibration
		wr(`ARPP_OFF0_ADDR, 32'h00AA);
		chk(`ARPP_OFF0_ADDR, 32'h0);
		wr(`ARPP_OFF1_ADDR, 32'h00BB);
		chk(`ARPP_OFF1_ADDR, 32'h00BB);
		cmp(4, offsCoef[1], 32'h00BB);
		repeat (`ARPP_COEF_WAIT) @(posedge ref_clk);
		wr(`ARPP_MODE_ADDR, 32'h0203);
		wr(`ARPP_GAIN1_ADDR, 32'h1234);
		chk(`ARPP_GAIN1_ADDR, 32'h8000);
		wr(`ARPP_MODE_ADDR, 32'h0304);
		i_flt.send(3, 0, 16'h4444);
		chk(`ARPP_OFF0_ADDR, 32'h4444);
		wr(`ARPP_MODE_ADDR, 32'h0305);
		i_flt.send(3, 2, 16'h5555);
		chk(`ARPP_GAIN2_ADDR, 32'h5555);
		cmp(5, gainCoef[2], 32'h5555);
		// Result counter
		wr(`ARPP_MODE_ADDR, 32'h0303);
		wr(`ARPP_CTRL_ADDR, 32'h8000);
		wr(`ARPP_CONFIG_ADDR, 32'h1);
		wr(`ARPP_RCL_ADDR, 32'h3);
		chk(`ARPP_STATUS_ADDR, 32'h0, 32'h100);
		repeat (2) i_flt.send(0, 0, 16'h0001);
		chk(`ARPP_RCV_ADDR, 32'h2);
		chk(`ARPP_STATUS_ADDR, 32'h0, 32'h100);
		i_flt.send(0, 0, 16'h0001);
		chk(`ARPP_RCV_ADDR, 32'h0);
		chk(`ARPP_STATUS_ADDR, 32'h100, 32'h100);
		i_flt.send(0, 0, 16'h0001);
		wr(`ARPP_MODE_ADDR, 32'h0303);
		chk(`ARPP_RCV_ADDR, 32'h0);
		i_flt.send(0, 0, 16'h0001);
		wr(`ARPP_CTRL_ADDR, 32'h8000);
		chk(`ARPP_RCV_ADDR, 32'h0);
		// Comparator: two's complement uses only low 15 threshold bits, unsigned uses all 16
		wr(`ARPP_TH_ADDR, 32'h8100);
		wr(`ARPP_THL_ADDR, 32'h2);
		wr(`ARPP_CONFIG_ADDR, 32'h90);
		i_flt.send(0, 0, 16'hFF00);
		chk(`ARPP_THV_ADDR, 32'h1);
		i_flt.send(0, 0, 16'h0050);
		chk(`ARPP_THV_ADDR, 32'h0);
		i_flt.send(0, 0, 16'hFF00);
		i_flt.send(0, 0, 16'h0100);
		chk(`ARPP_STATUS_ADDR, 32'h40, 32'h40);
		wr(`ARPP_CONFIG_ADDR, 32'h98);
		i_flt.send(0, 0, 16'h0050);
		chk(`ARPP_THV_ADDR, 32'h1);
		wr(`ARPP_CONFIG_ADDR, 32'h88);
		i_flt.send(0, 0, 16'h0100);
		chk(`ARPP_STATUS_ADDR, 32'h40, 32'h40);
		wr(`ARPP_CONFIG_ADDR, 32'h80);
		i_flt.send(0, 0, 16'hFF00);
		chk(`ARPP_STATUS_ADDR, 32'h0, 32'h40);
		wr(`ARPP_CONFIG_ADDR, 32'h08);
		i_flt.send(0, 0, 16'h0100);
		chk(`ARPP_STATUS_ADDR, 32'h0, 32'h40);
		// Accumulator
		wr(`ARPP_CONFIG_ADDR, 32'h20);
		wr(`ARPP_ATH_ADDR, 32'h150);
		repeat (2) i_flt.send(0, 0, 16'h0100);
		chk(`ARPP_STATUS_ADDR, 32'h81, 32'h81);
		chk(`ARPP_ACC_ADDR, 32'h200);
		wr(`ARPP_CONFIG_ADDR, 32'h0);
		chk(`ARPP_ACC_ADDR, 32'h0);
		wr(`ARPP_CONFIG_ADDR, 32'h40);
		i_flt.send(0, 0, 16'h0010);
		chk(`ARPP_ACC_ADDR, 32'hFFFFFFF0);
		wr(`ARPP_CTRL_ADDR, 32'h8000);
		chk(`ARPP_ACC_ADDR, 32'h0);
		// Paired result queue
		chk(`ARPP_CUR_ADDR, 32'h0, 32'h0);
		wr(`ARPP_CONFIG_ADDR, 32'h2);
		i_flt.send(1, 0, 16'h7777);
		i_flt.send(0, 0, 16'h1001);
		chk(`ARPP_STATUS_ADDR, 32'h8, 32'h8);
		chk(`ARPP_QUEUE_ADDR, 32'h77771001);
		chk(`ARPP_STATUS_ADDR, 32'h0, 32'h8);
		repeat (32) i_flt.send(0, 0, 16'h3003);
		chk(`ARPP_STATUS_ADDR, 32'h18, 32'h38);
		i_flt.send(0, 0, 16'h3003);
		chk(`ARPP_STATUS_ADDR, 32'h38, 32'h38);
		wr(`ARPP_CONFIG_ADDR, 32'h0);
		i_flt.send(0, 0, 16'h2002);
		chk(`ARPP_STATUS_ADDR, 32'h0, 32'h8);
		stop_test();
	end
endmodule
